// ---- rtl/rvc_consts.vh ----
// Offsets, field positions and reset values of the rail voltage code bank.
// Assumes an 8-bit register access port supplied by the serial bus logic.
`ifndef RVC_CONSTS_VH
`define RVC_CONSTS_VH

`define RVC_ADDR_W 8
`define RVC_DATA_W 8
`define RVC_CODE_W 7
`define RVC_OFF_R4_SLEEP 8'h95
`define RVC_OFF_R5_NORMAL 8'h96
`define RVC_OFF_R5_SLEEP 8'h97
`define RVC_OFF_R6_NORMAL 8'h98
`define RVC_OFF_R6_SLEEP 8'h99
`define RVC_CODE_MSB 7
`define RVC_CODE_LSB 1
`define RVC_FALL_BIT 0
`define RVC_RESET_VALUE 8'h00

`endif

// ---- rtl/rvc_code_select.v ----
// Picks the sleep code or the normal code of one rail.
// Assumes the sleep level is already in the MCLK domain.
`timescale 1ns/1ps
`default_nettype none
module rvc_code_select #(
  parameter CODE_W = 7
) (
  input wire mclk,
  input wire rst_n,
  input wire sleep,
  input wire [CODE_W-1:0] normal_code,
  input wire [CODE_W-1:0] sleep_code,
  output reg [CODE_W-1:0] active_code
);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_code <= {CODE_W{1'b0}};
    end else begin
      active_code <= sleep ? sleep_code : normal_code; // [R8]
    end
  end
endmodule // rvc_code_select
`default_nettype wire

// ---- rtl/rvc_rail_voltage_regs.v ----
// Register bank of sleep voltage codes for rails 4, 5 and 6 and normal voltage codes for rails 5 and 6.
// Assumes a serial bus front end presenting one-cycle write/read strobes
// with an 8-bit offset, all on MCLK; sleep inputs come from pins.
`timescale 1ns/1ps
`default_nettype none
`include "rvc_consts.vh"

// What this block does
// (R1) Rail 4 sleep register bits 7:1 hold the 25 mV step sleep code.
// (R2) Rail 5 normal register at 96h bits 7:1 hold its 25 mV normal code.
// (R3) Rail 5 sleep register at 97h holds the sleep code; bit 0 reads 0.
// (R4) Bit 0 of rail 5 and 6 normal registers picks slew (0) or decay (1).
// (R5) Rail 6 normal register at 98h holds a code read in 10 or 25 mV steps.
// (R6) Rail 6 sleep register at 99h holds its sleep code; bit 0 reads 0.
// (R7) Rail 4 sleep register sits at 95h, bit 0 reserved and read-only.
// (R8) A rail uses its sleep code only while asleep, else its normal code.
module rvc_rail_voltage_regs #(
  parameter CODE_W = `RVC_CODE_W
) (
  input wire MCLK,
  input wire RST_N,
  input wire WR_EN,
  input wire RD_EN,
  input wire [`RVC_ADDR_W-1:0] ADDR,
  input wire [`RVC_DATA_W-1:0] WDATA,
  input wire RAIL4_SLEEP,
  input wire RAIL5_SLEEP,
  input wire RAIL6_SLEEP,
  input wire [CODE_W-1:0] RAIL4_NORMAL_CODE,
  output reg [`RVC_DATA_W-1:0] RDATA,
  output reg RDATA_VALID,
  output wire [CODE_W-1:0] RAIL4_CODE,
  output wire [CODE_W-1:0] RAIL5_CODE,
  output wire [CODE_W-1:0] RAIL6_CODE,
  output reg RAIL5_FREE_FALL,
  output reg RAIL6_FREE_FALL
);
  reg [CODE_W-1:0] rail4_sleep_voltage_code;
  reg [CODE_W-1:0] rail5_normal_voltage_code;
  reg [CODE_W-1:0] rail5_sleep_voltage_code;
  reg [CODE_W-1:0] rail6_normal_voltage_code;
  reg [CODE_W-1:0] rail6_sleep_voltage_code;
  reg [2:0] sleep_meta;
  reg [2:0] sleep_sync;
  reg [`RVC_DATA_W-1:0] next_rdata;

  // Sleep pins are asynchronous; two flops before use
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sleep_meta <= 3'h0;
      sleep_sync <= 3'h0;
    end else begin
      sleep_meta <= {RAIL6_SLEEP, RAIL5_SLEEP, RAIL4_SLEEP};
      sleep_sync <= sleep_meta;
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rail4_sleep_voltage_code <= {CODE_W{1'b0}};
      rail5_normal_voltage_code <= {CODE_W{1'b0}};
      rail5_sleep_voltage_code <= {CODE_W{1'b0}};
      rail6_normal_voltage_code <= {CODE_W{1'b0}};
      rail6_sleep_voltage_code <= {CODE_W{1'b0}};
      RAIL5_FREE_FALL <= 1'b0;
      RAIL6_FREE_FALL <= 1'b0;
    end else if (WR_EN) begin
      case (ADDR)
        `RVC_OFF_R4_SLEEP: begin
          // Bit 0 reserved, write ignored
          rail4_sleep_voltage_code <=
            WDATA[`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R1] [R7]
        end
        `RVC_OFF_R5_NORMAL: begin
          rail5_normal_voltage_code <=
            WDATA[`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R2]
          RAIL5_FREE_FALL <= WDATA[`RVC_FALL_BIT]; // [R4]
        end
        `RVC_OFF_R5_SLEEP: begin
          rail5_sleep_voltage_code <=
            WDATA[`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R3]
        end
        `RVC_OFF_R6_NORMAL: begin
          // Step range is chosen elsewhere; code stored as is
          rail6_normal_voltage_code <=
            WDATA[`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R5]
          RAIL6_FREE_FALL <= WDATA[`RVC_FALL_BIT]; // [R4]
        end
        `RVC_OFF_R6_SLEEP: begin
          rail6_sleep_voltage_code <=
            WDATA[`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R6]
        end
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (ADDR)
      `RVC_OFF_R4_SLEEP: next_rdata = {rail4_sleep_voltage_code, 1'b0}; // [R7]
      `RVC_OFF_R5_NORMAL:
        next_rdata = {rail5_normal_voltage_code, RAIL5_FREE_FALL}; // [R4]
      `RVC_OFF_R5_SLEEP: next_rdata = {rail5_sleep_voltage_code, 1'b0}; // [R3]
      `RVC_OFF_R6_NORMAL:
        next_rdata = {rail6_normal_voltage_code, RAIL6_FREE_FALL}; // [R5]
      `RVC_OFF_R6_SLEEP: next_rdata = {rail6_sleep_voltage_code, 1'b0}; // [R6]
      default: next_rdata = `RVC_RESET_VALUE;
    endcase
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= `RVC_RESET_VALUE;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= RD_EN;
      if (RD_EN) begin
        RDATA <= next_rdata;
      end
    end
  end

  rvc_code_select #(.CODE_W(CODE_W)) u_sel4 (
    .mclk(MCLK),
    .rst_n(RST_N),
    .sleep(sleep_sync[0]),
    .normal_code(RAIL4_NORMAL_CODE),
    .sleep_code(rail4_sleep_voltage_code),
    .active_code(RAIL4_CODE)
  );
  rvc_code_select #(.CODE_W(CODE_W)) u_sel5 (
    .mclk(MCLK),
    .rst_n(RST_N),
    .sleep(sleep_sync[1]),
    .normal_code(rail5_normal_voltage_code),
    .sleep_code(rail5_sleep_voltage_code),
    .active_code(RAIL5_CODE)
  );
  rvc_code_select #(.CODE_W(CODE_W)) u_sel6 (
    .mclk(MCLK),
    .rst_n(RST_N),
    .sleep(sleep_sync[2]),
    .normal_code(rail6_normal_voltage_code),
    .sleep_code(rail6_sleep_voltage_code),
    .active_code(RAIL6_CODE)
  );
endmodule // rvc_rail_voltage_regs
`default_nettype wire

// ---- dv/rvc_props.sv ----
// Port checker of the rail code bank, bound to its top module.
// Assumes the default 7-bit code width.
`timescale 1ns/1ps
`default_nettype none
module rvc_props(
  input wire logic MCLK, RST_N, WR_EN, RD_EN, RDATA_VALID, RAIL5_SLEEP,
  input wire logic RAIL6_SLEEP, RAIL5_FREE_FALL, RAIL6_FREE_FALL,
  input wire logic [7:0] ADDR, WDATA, RDATA,
  input wire logic [6:0] RAIL5_CODE, RAIL6_CODE);
  wire logic hit = ADDR >= 8'h95 && ADDR <= 8'h99;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  property p_vld; RDATA_VALID == $past(RD_EN); endproperty
  a_vld: assert property (p_vld) else $error("valid");
  property p_hld; !RD_EN |=> $stable(RDATA); endproperty
  a_hld: assert property (p_hld) else $error("hold");
  property p_map; RD_EN && !hit |=> RDATA == 8'h00; endproperty
  a_map: assert property (p_map) else $error("unmapped");
  property p_rsv; RD_EN && hit && ADDR[0] |=> !RDATA[0]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_ff5; WR_EN && ADDR == 8'h96 |=> RAIL5_FREE_FALL == $past(WDATA[0]);
  endproperty
  a_ff5: assert property (p_ff5) else $error("fall5");
  property p_ff6; WR_EN && ADDR == 8'h98 |=> RAIL6_FREE_FALL == $past(WDATA[0]);
  endproperty
  a_ff6: assert property (p_ff6) else $error("fall6");
  // Sleep pin held high or low long enough to pass the two-flop synchroniser
  property p_s5; RAIL5_SLEEP [*4] ##0 (WR_EN && ADDR == 8'h97)
    |-> ##2 RAIL5_CODE == $past(WDATA[7:1], 2); endproperty
  a_s5: assert property (p_s5) else $error("sleep5");
  property p_n6; !RAIL6_SLEEP [*4] ##0 (WR_EN && ADDR == 8'h98)
    |-> ##2 RAIL6_CODE == $past(WDATA[7:1], 2); endproperty
  a_n6: assert property (p_n6) else $error("normal6");
  c_rd: cover property (RDATA_VALID && RDATA[0]);
  c_s5: cover property (RAIL5_SLEEP && WR_EN && ADDR == 8'h97);
  c_ff: cover property ($rose(RAIL6_FREE_FALL));
endmodule // rvc_props
bind rvc_rail_voltage_regs rvc_props rvc_props_i(.*);
`default_nettype wire

// ---- dv/rvc_host.sv ----
// Host model: one-cycle register strobes just after MCLK rises.
// Assumes reads are answered one edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module rvc_host(
  input wire logic MCLK,
  output logic WR_EN = 0, RD_EN = 0,
  output logic [7:0] ADDR = 8'h00, WDATA = 8'h00,
  input wire logic [7:0] RDATA,
  input wire logic RDATA_VALID);
  task op(input logic w, input logic [7:0] a, d,
    output logic [7:0] q, output logic v);
    @(posedge MCLK) #1 {WR_EN, RD_EN, ADDR, WDATA} = {w, !w, a, d};
    // Released bus shows inverted values, never the stale ones
    @(posedge MCLK) #1 {WR_EN, RD_EN, ADDR, WDATA} = {2'b00, ~a, ~d};
    {q, v} = {RDATA, RDATA_VALID};
  endtask
endmodule // rvc_host
`default_nettype wire

// ---- dv/rvc_rail_voltage_regs_tb.sv ----
// Random writes, read-back and sleep pins against a register model.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module rvc_rail_voltage_regs_tb;
  logic MCLK = 0, RST_N = 0, WR_EN, RD_EN, RDATA_VALID, v;
  logic RAIL4_SLEEP = 0, RAIL5_SLEEP = 0, RAIL6_SLEEP = 0;
  logic RAIL5_FREE_FALL, RAIL6_FREE_FALL;
  logic [6:0] RAIL4_NORMAL_CODE = 7'h00, RAIL4_CODE, RAIL5_CODE, RAIL6_CODE;
  logic [7:0] ADDR, WDATA, RDATA, q, a, m [8'h95:8'h99];
  logic [31:0] r = 32'hf622;
  int num_errors = 0, comparisons = 0;
  always #2.5 MCLK = ~MCLK;
  rvc_host rvc_host_i(.*);
  rvc_rail_voltage_regs rvc_rail_voltage_regs_i(.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ex(input logic [7:0] x);
    return x >= 8'h95 && x <= 8'h99 ? m[x] : 8'h00;
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) num_errors++;
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
  endtask
  task summarize;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    foreach (m[i]) m[i] = 8'h00;
    repeat (12) @(posedge MCLK);
    #1 RST_N = 1;
    for (int i = 0; i < 208; i++) begin
      r = lfsr(r);
      a = i < 8 ? 8'h93 + i[7:0] : 8'h94 + {5'h00, r[2:0]};
      if (i >= 8) begin
        rvc_host_i.op(1, a, r[15:8], q, v);
        if (a >= 8'h95 && a <= 8'h99) m[a] = r[15:8] & {7'h7f, ~a[0]};
      end
      rvc_host_i.op(0, a, 8'h00, q, v);
      chk("rdata", ex(a), q);
      chk("valid", 8'h01, {7'h00, v});
      {RAIL6_SLEEP, RAIL5_SLEEP, RAIL4_SLEEP} = r[18:16];
      RAIL4_NORMAL_CODE = r[30:24];
      #21;
      chk("rail4", RAIL4_SLEEP ? m[8'h95] >> 1 : {1'b0, r[30:24]},
        {1'b0, RAIL4_CODE});
      chk("rail5", m[RAIL5_SLEEP ? 8'h97 : 8'h96] >> 1,
        {1'b0, RAIL5_CODE});
      chk("rail6", m[RAIL6_SLEEP ? 8'h99 : 8'h98] >> 1,
        {1'b0, RAIL6_CODE});
      chk("fall", {6'h00, m[8'h98][0], m[8'h96][0]},
        {6'h00, RAIL6_FREE_FALL, RAIL5_FREE_FALL});
      if (i == 7) $display("test reset values done");
    end
    $display("test random traffic done");
    summarize;
  end
endmodule // rvc_rail_voltage_regs_tb
`default_nettype wire
